//--- hdl/rsq_cfg.svh
// constants of the reset output and soft reset sequencer
// assumes a 200 MHz pclk and an APB master in the same clock domain
//
// Notes on behaviour
// - reset event drives reset_out_n low only after the reset filter time
// - reset output stays low while the event lasts, then for the delay
// - delay defaults to extended; reduced delay when reset_delay_select is set
// - power-up starts low, released after extended delay once supply is good
// - watchdog failure is a reset event like undervoltage
// - undervoltage threshold select is programmable, lowest setting after reset
// - accepted soft reset returns to init mode and restores register defaults
// - soft reset pin option 0 asserts reset output with extended delay
// - soft reset pin option 1 resets internally without touching the pin
// - soft reset only accepted in normal or stop mode, otherwise ignored
// - watchdog expiry asserts reset and enters restart or fail-safe mode
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define RSQ_OFF_MODE 12'h000
`define RSQ_OFF_CFG 12'h004
`define RSQ_OFF_STAT 12'h008

// -----------------------------------------------------------------
// field positions and values
// -----------------------------------------------------------------
`define RSQ_MODE_INIT 2'h0
`define RSQ_MODE_NORMAL 2'h1
`define RSQ_MODE_STOP 2'h2
`define RSQ_MODE_SOFT_RESET 2'h3
`define RSQ_CFG_DEL_BIT 0
`define RSQ_CFG_SRPIN_BIT 1
`define RSQ_CFG_FAILSAFE_BIT 2
`define RSQ_CFG_THR_LSB 4
`define RSQ_STAT_WDC_BIT 5
`define RSQ_THR_RESET 2'h0
`define RSQ_CFG_RESET 32'h0000_0000

// -----------------------------------------------------------------
// timing, in nanoseconds and cycles of pclk
// -----------------------------------------------------------------
`define RSQ_CLK_PERIOD_NS 5
`define RSQ_FILTER_NS 10000
`define RSQ_EXT_DELAY_NS 10000000
`define RSQ_RED_DELAY_NS 2000000
`define RSQ_FILTER_CYC ((`RSQ_FILTER_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_EXT_DELAY_CYC ((`RSQ_EXT_DELAY_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_RED_DELAY_CYC ((`RSQ_RED_DELAY_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)

`endif

//--- hdl/rsq_pkg.sv
// types of the reset output and soft reset sequencer
// assumes nothing beyond the constants header
package rsq_pkg;

  // reset output sequencer states
  typedef enum logic [3:0] {
    RSQ_ST_POWERUP = 4'h1,
    RSQ_ST_RUN = 4'h2,
    RSQ_ST_FILTER = 4'h4,
    RSQ_ST_HOLD = 4'h8
  } rsq_state_t;

  // operating modes of the device
  typedef enum logic [2:0] {
    RSQ_OP_INIT = 3'h0,
    RSQ_OP_NORMAL = 3'h1,
    RSQ_OP_STOP = 3'h2,
    RSQ_OP_RESTART = 3'h3,
    RSQ_OP_FAILSAFE = 3'h4
  } rsq_opmode_t;

endpackage

//--- hdl/rsq_sync.sv
// three-stage input synchroniser with agreement of the last two stages
// assumes an asynchronous input and a single clock domain
module rsq_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  input wire logic reset_value,
  output logic sync_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;
  logic out_next;

  // stage two and three must agree before the output follows
  assign out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  // the chain holds the input relative to its reset level, so a cleared chain reads reset_value
  assign sync_out = out_reg ^ reset_value;

  // ---------------------------------------------------------------
  // flip-flop chain
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= async_in ^ reset_value;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end
endmodule

//--- hdl/rsq_reset_seq.sv
// reset output sequencer with apb registers and soft reset handling
// assumes an apb master on pclk; supply and watchdog flags arrive asynchronously
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`include "rsq_cfg.svh"

module rsq_reset_seq
  import rsq_pkg::*;
#(
  parameter int unsigned FILTER_CYC = `RSQ_FILTER_CYC,
  parameter int unsigned EXT_DELAY_CYC = `RSQ_EXT_DELAY_CYC,
  parameter int unsigned RED_DELAY_CYC = `RSQ_RED_DELAY_CYC,
  parameter int unsigned CNT_W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_undervoltage,
  input wire logic watchdog_fail,
  output logic reset_out_n,
  output logic [1:0] threshold_select,
  output logic [2:0] op_mode,
  output logic soft_reset_pulse
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rsq_state_t state_reg;
  rsq_state_t state_next;
  rsq_opmode_t mode_reg;
  rsq_opmode_t mode_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic del_sel_reg;
  logic srpin_reg;
  logic failsafe_reg;
  logic [1:0] thr_reg;
  logic rst_n_reg;
  logic soft_reg;
  logic wd_cause_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  logic uv_sync;
  logic wd_sync;
  logic event_now;
  logic wr_fire;
  logic rd_fire;
  logic hit_mode;
  logic hit_cfg;
  logic hit_stat;
  logic soft_req;
  logic soft_ok;
  logic [CNT_W-1:0] delay_cyc;
  logic delay_done;
  logic filter_done;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  rsq_sync u_uv_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(supply_undervoltage),
    .reset_value(1'b1),
    .sync_out(uv_sync)
  );

  rsq_sync u_wd_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(watchdog_fail),
    .reset_value(1'b0),
    .sync_out(wd_sync)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign wr_fire = psel & penable & pwrite;
  assign rd_fire = psel & penable & ~pwrite;
  assign hit_mode = (paddr == `RSQ_OFF_MODE);
  assign hit_cfg = (paddr == `RSQ_OFF_CFG);
  assign hit_stat = (paddr == `RSQ_OFF_STAT);
  assign soft_req = wr_fire & hit_mode & (pwdata[1:0] == `RSQ_MODE_SOFT_RESET);
  assign soft_ok = soft_req & ((mode_reg == RSQ_OP_NORMAL) | (mode_reg == RSQ_OP_STOP));
  assign rd_mux = hit_mode ? {29'h0, mode_reg} :
                  hit_cfg ? {26'h0, thr_reg, 1'b0, failsafe_reg, srpin_reg, del_sel_reg} :
                  hit_stat ? {26'h0, wd_cause_reg, wd_sync, uv_sync, ~rst_n_reg, 2'h0} | {28'h0, state_reg} :
                  32'h0000_0000;

  // ---------------------------------------------------------------
  // sequencer decode
  // ---------------------------------------------------------------
  // undervoltage or watchdog failure both count as reset events
  assign event_now = uv_sync | wd_sync;
  assign delay_cyc = del_sel_reg ? CNT_W'(RED_DELAY_CYC) : CNT_W'(EXT_DELAY_CYC);
  assign filter_done = (cnt_reg >= CNT_W'(FILTER_CYC - 1));
  assign delay_done = (cnt_reg >= delay_cyc - CNT_W'(1));

  // next state of the reset output sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + CNT_W'(1);
    case (state_reg)
      RSQ_ST_POWERUP: begin
        // held low, extended delay once supply is good
        if (uv_sync) begin
          cnt_next = '0;
        end else if (cnt_reg >= CNT_W'(EXT_DELAY_CYC - 1)) begin
          state_next = RSQ_ST_RUN;
          cnt_next = '0;
        end
      end
      RSQ_ST_RUN: begin
        cnt_next = '0;
        if (soft_ok & ~srpin_reg) begin
          state_next = RSQ_ST_POWERUP;
        end else if (event_now) begin
          state_next = RSQ_ST_FILTER;
        end
      end
      RSQ_ST_FILTER: begin
        if (!event_now) begin
          state_next = RSQ_ST_RUN;
          cnt_next = '0;
        end else if (filter_done) begin
          state_next = RSQ_ST_HOLD;
          cnt_next = '0;
        end
      end
      RSQ_ST_HOLD: begin
        if (event_now) begin
          cnt_next = '0;
        end else if (delay_done) begin
          state_next = RSQ_ST_RUN;
          cnt_next = '0;
        end
      end
      default: begin
        state_next = RSQ_ST_POWERUP;
        cnt_next = '0;
      end
    endcase
    // a soft reset with the pin option clear restarts the power-up delay from any state
    if (soft_ok & ~srpin_reg) begin
      state_next = RSQ_ST_POWERUP;
      cnt_next = '0;
    end
  end

  // operating mode follows soft reset, watchdog failure and writes
  always_comb begin
    mode_next = mode_reg;
    if (soft_ok) begin
      mode_next = RSQ_OP_INIT;
    end else if (state_reg == RSQ_ST_FILTER && filter_done && wd_sync) begin
      mode_next = failsafe_reg ? RSQ_OP_FAILSAFE : RSQ_OP_RESTART;
    end else if (state_next == RSQ_ST_RUN && state_reg != RSQ_ST_RUN && mode_reg == RSQ_OP_RESTART) begin
      mode_next = RSQ_OP_NORMAL;
    end else if (wr_fire && hit_mode && pwdata[1:0] != `RSQ_MODE_SOFT_RESET
                 && mode_reg != RSQ_OP_FAILSAFE) begin
      mode_next = (pwdata[1:0] == `RSQ_MODE_STOP) ? RSQ_OP_STOP :
                  (pwdata[1:0] == `RSQ_MODE_NORMAL) ? RSQ_OP_NORMAL : RSQ_OP_INIT;
    end
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RSQ_ST_POWERUP;
      cnt_reg <= '0;
      rst_n_reg <= 1'b0;
      mode_reg <= RSQ_OP_INIT;
      soft_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rst_n_reg <= (state_next == RSQ_ST_RUN) | (state_next == RSQ_ST_FILTER);
      mode_reg <= mode_next;
      soft_reg <= soft_ok;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      del_sel_reg <= 1'b0;
      srpin_reg <= 1'b0;
      failsafe_reg <= 1'b0;
      thr_reg <= `RSQ_THR_RESET;
      wd_cause_reg <= 1'b0;
    end else if (soft_ok) begin
      del_sel_reg <= 1'b0;
      srpin_reg <= 1'b0;
      failsafe_reg <= 1'b0;
      thr_reg <= `RSQ_THR_RESET;
      wd_cause_reg <= 1'b0;
    end else begin
      if (wr_fire && hit_cfg) begin
        del_sel_reg <= pwdata[`RSQ_CFG_DEL_BIT];
        srpin_reg <= pwdata[`RSQ_CFG_SRPIN_BIT];
        failsafe_reg <= pwdata[`RSQ_CFG_FAILSAFE_BIT];
        thr_reg <= pwdata[`RSQ_CFG_THR_LSB +: 2];
      end
      // sticky watchdog cause; set wins over a write-one clear
      if (state_reg == RSQ_ST_FILTER && filter_done && wd_sync) begin
        wd_cause_reg <= 1'b1;
      end else if (wr_fire && hit_stat && pwdata[`RSQ_STAT_WDC_BIT]) begin
        wd_cause_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // apb answer, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      prdata_reg <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_reg;
      pslverr_reg <= psel & ~penable & ~(hit_mode | hit_cfg | hit_stat); // high in the access cycle only
      pready_reg <= 1'b1; // every access completes in its first cycle
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign reset_out_n = rst_n_reg;
  assign threshold_select = thr_reg;
  assign op_mode = mode_reg;
  assign soft_reset_pulse = soft_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_filter_low: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_reg == RSQ_ST_FILTER) |-> reset_out_n [*2])
    else $error("reset output fell before filter time");
  chk_hold_low: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RSQ_ST_HOLD && event_now) |=> !reset_out_n)
    else $error("reset output released while event present");
  chk_thr_default: assert property (@(posedge pclk) disable iff (!presetn)
    soft_ok |=> threshold_select == `RSQ_THR_RESET)
    else $error("threshold not restored");
  chk_soft_init: assert property (@(posedge pclk) disable iff (!presetn)
    soft_ok |=> op_mode == RSQ_OP_INIT && soft_reset_pulse)
    else $error("soft reset did not enter init");
  chk_soft_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_ok && !srpin_reg) |=> !reset_out_n ##1 !reset_out_n)
    else $error("soft reset did not assert pin");
  chk_soft_nopin: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_ok && srpin_reg && reset_out_n && !event_now) |=> reset_out_n)
    else $error("soft reset touched pin");
  chk_soft_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_req && mode_reg != RSQ_OP_NORMAL && mode_reg != RSQ_OP_STOP) |=> !soft_reset_pulse)
    else $error("soft reset accepted in wrong mode");
  chk_wd_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RSQ_ST_FILTER && filter_done && wd_sync && !soft_ok)
    |=> !reset_out_n && (op_mode == RSQ_OP_RESTART || op_mode == RSQ_OP_FAILSAFE))
    else $error("watchdog failure not handled");
  chk_delay_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(state_reg == RSQ_ST_HOLD) && !$past(event_now) && !$past(soft_ok))
    |-> $past(cnt_reg) >= ($past(del_sel_reg) ? CNT_W'(RED_DELAY_CYC - 1) : CNT_W'(EXT_DELAY_CYC - 1)))
    else $error("release before delay");
  // the pin stays low for the whole power-up wait
  chk_powerup_low: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RSQ_ST_POWERUP) |-> !reset_out_n)
    else $error("reset output high during power-up");
  // a returning event restarts the delay count
  chk_cnt_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RSQ_ST_HOLD && event_now) |=> (cnt_reg == '0))
    else $error("delay counter not restarted");
  // watchdog failure alone starts the filter like undervoltage
  chk_wd_event: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RSQ_ST_RUN && wd_sync && !soft_ok) |=> (state_reg == RSQ_ST_FILTER))
    else $error("watchdog failure not taken as event");
  // the watchdog cause is recorded even against a clear
  chk_cause_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RSQ_ST_FILTER && filter_done && wd_sync && !soft_ok) |=> wd_cause_reg)
    else $error("watchdog cause not recorded");
  // an access to no register answers with an error
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !hit_mode && !hit_cfg && !hit_stat) |=> pslverr)
    else $error("unmapped access without error");
  // the soft reset pulse lasts one cycle
  chk_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
endmodule

//--- verif/rsq_host_model.sv
// host side model: apb master issuing commands to the reset sequencer
// assumes pclk and presetn from the bench; slave may add wait states
`include "rsq_cfg.svh"
module rsq_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reset_out_n,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_err;
  int n_resets;
  // ----------------------------------------------------------------
  // bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    last_err = 1'b0;
    n_resets = 0;
  end
  // counts resets seen by the host outside its own reset
  always @(negedge reset_out_n) if (presetn === 1'b1) n_resets++;
  // one transfer, request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wdata; // released data does not keep showing
  endtask
  // soft reset request: mode field written with binary 11
  task automatic soft_reset();
    logic [31:0] d;
    xfer(1'b1, `RSQ_OFF_MODE, {30'h0000_0000, `RSQ_MODE_SOFT_RESET}, d);
  endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench of the reset sequencer driven through the host model
// assumes shortened filter and delay counts set as parameters here
`include "rsq_cfg.svh"
module tb_top import rsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FILT = 4;
  localparam int EXT = 40;
  localparam int RED = 20;
  typedef struct {logic is_uv; logic del; int dly;} rsq_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic uv = 1'b1;
  logic wd = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, reset_out_n, soft_reset_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] threshold_select;
  logic [2:0] op_mode;
  int n_errors = 0;
  int n_checks = 0;
  int n_pulse = 0;
  int n;
  int n_rst;
  rsq_row_t rows [4] = '{'{1'b1, 1'b0, EXT}, '{1'b1, 1'b1, RED}, '{1'b0, 1'b0, EXT}, '{1'b0, 1'b1, RED}};
  // ----------------------------------------------------------------
  // clock, pulse counter, instances
  // ----------------------------------------------------------------
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (soft_reset_pulse === 1'b1) n_pulse++;
  rsq_reset_seq #(.FILTER_CYC(FILT), .EXT_DELAY_CYC(EXT), .RED_DELAY_CYC(RED)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_undervoltage(uv),
    .watchdog_fail(wd), .reset_out_n(reset_out_n), .threshold_select(threshold_select), .op_mode(op_mode),
    .soft_reset_pulse(soft_reset_pulse));
  rsq_host_model host (
    .pclk(pclk), .presetn(presetn), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_out_n(reset_out_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ----------------------------------------------------------------
  // compare helpers and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // cycles until the reset output reaches lvl, bounded
  task automatic wait_out(input logic lvl, output int cnt);
    cnt = 0;
    while (reset_out_n !== lvl && cnt < 200) begin
      @(posedge pclk);
      cnt++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the fewer than a thousand cycles the tests need
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    chk("reset_out_n in reset", 32'h0, 32'(reset_out_n));
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    uv <= 1'b0;
    wait_out(1'b1, n);
    chk_rng("power-up release", EXT, EXT + 6, n);
    chk("threshold after reset", 32'(`RSQ_THR_RESET), 32'(threshold_select));
    chk("pready high", 32'h1, 32'(pready));
    host.xfer(1'b0, `RSQ_OFF_CFG, 32'h0000_0000, rd);
    chk("cfg reset value", `RSQ_CFG_RESET, rd);
    host.xfer(1'b1, `RSQ_OFF_CFG, 32'h0000_0020, rd);
    @(posedge pclk);
    chk("threshold written", 32'h2, 32'(threshold_select));
    host.soft_reset();
    repeat (4) @(posedge pclk);
    chk("soft reset in init ignored", 32'h0, 32'(n_pulse));
    chk("threshold kept", 32'h2, 32'(threshold_select));
    host.xfer(1'b0, 12'h00C, 32'h0000_0000, rd);
    chk("unmapped error", 32'h1, 32'(host.last_err));
    $display("power-up and init tests done");
    // ordinary reset events from the table
    foreach (rows[i]) begin
      host.xfer(1'b1, `RSQ_OFF_MODE, 32'h0000_0001, rd);
      host.xfer(1'b1, `RSQ_OFF_CFG, 32'(rows[i].del), rd);
      if (rows[i].is_uv) uv <= 1'b1; else wd <= 1'b1;
      wait_out(1'b0, n);
      chk_rng("filter cycles", FILT + 2, FILT + 6, n);
      repeat (20) @(posedge pclk);
      chk("reset_out_n held", 32'h0, 32'(reset_out_n));
      if (!rows[i].is_uv) chk("watchdog mode", 32'(RSQ_OP_RESTART), 32'(op_mode));
      uv <= 1'b0;
      wd <= 1'b0;
      wait_out(1'b1, n);
      chk_rng("release delay", rows[i].dly, rows[i].dly + 6, n);
      $display("row %0d done", i);
    end
    // short event dropped mid-filter, then a full one
    uv <= 1'b1;
    repeat (3) @(posedge pclk);
    uv <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("no reset on short event", 32'h1, 32'(reset_out_n));
    uv <= 1'b1;
    wait_out(1'b0, n);
    chk_rng("filter restarted", FILT + 2, FILT + 6, n);
    uv <= 1'b0;
    wait_out(1'b1, n);
    $display("filter restart test done");
    // status shows the recorded watchdog cause, a write of one clears it
    host.xfer(1'b0, `RSQ_OFF_STAT, 32'h0000_0000, rd);
    chk("status after watchdog", 32'h0000_0022, rd);
    host.xfer(1'b1, `RSQ_OFF_STAT, 32'h0000_0020, rd);
    host.xfer(1'b0, `RSQ_OFF_STAT, 32'h0000_0000, rd);
    chk("status cause cleared", 32'h0000_0002, rd);
    $display("status test done");
    // soft reset in normal mode, pin option 0
    host.xfer(1'b1, `RSQ_OFF_CFG, 32'h0000_0021, rd);
    host.xfer(1'b1, `RSQ_OFF_MODE, 32'h0000_0001, rd);
    host.soft_reset();
    repeat (3) @(posedge pclk);
    chk("soft reset pulse", 32'h1, 32'(n_pulse));
    chk("pin asserted", 32'h0, 32'(reset_out_n));
    chk("threshold restored", 32'h0, 32'(threshold_select));
    chk("mode back to init", 32'(RSQ_OP_INIT), 32'(op_mode));
    wait_out(1'b1, n);
    chk_rng("soft reset delay", EXT - 4, EXT + 6, n);
    // soft reset in stop mode, pin option 1
    host.xfer(1'b1, `RSQ_OFF_CFG, 32'h0000_0023, rd);
    host.xfer(1'b1, `RSQ_OFF_MODE, 32'h0000_0002, rd);
    n_rst = host.n_resets;
    host.soft_reset();
    repeat (3) @(posedge pclk);
    chk("stop mode soft reset", 32'h2, 32'(n_pulse));
    wait_out(1'b0, n);
    chk("pin untouched", 32'h1, 32'(reset_out_n));
    chk("no reset edge", 32'(n_rst), 32'(host.n_resets));
    host.xfer(1'b0, `RSQ_OFF_CFG, 32'h0000_0000, rd);
    chk("cfg restored", `RSQ_CFG_RESET, rd);
    $display("soft reset tests done");
    // watchdog failure with the fail-safe option, mode writes and soft reset refused there
    host.xfer(1'b1, `RSQ_OFF_MODE, 32'h0000_0001, rd);
    host.xfer(1'b1, `RSQ_OFF_CFG, 32'h0000_0004, rd);
    wd <= 1'b1;
    wait_out(1'b0, n);
    chk("fail-safe mode", 32'(RSQ_OP_FAILSAFE), 32'(op_mode));
    wd <= 1'b0;
    wait_out(1'b1, n);
    chk_rng("fail-safe release", EXT, EXT + 6, n);
    host.xfer(1'b1, `RSQ_OFF_MODE, 32'h0000_0001, rd);
    @(posedge pclk);
    chk("mode write refused", 32'(RSQ_OP_FAILSAFE), 32'(op_mode));
    host.soft_reset();
    repeat (3) @(posedge pclk);
    chk("soft reset refused", 32'h2, 32'(n_pulse));
    $display("fail-safe test done");
    // reset in mid-run returns to the power-up state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("mode after reset", 32'(RSQ_OP_INIT), 32'(op_mode));
    chk("pin after reset", 32'h0, 32'(reset_out_n));
    presetn <= 1'b1;
    wait_out(1'b1, n);
    chk_rng("release after reset", EXT, EXT + 6, n);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule
